//--- sep_pkg.sv
/*
 * Constants, state codes and carrier types for the two-wire EEPROM read and busy-poll slave.
 * Assumes a 25 MHz system clock and bus pins already synchronous to it.
 */
package sep_pkg;

	localparam int          ADDR_W        = 8;
	localparam int          DATA_W        = 8;
	localparam int          MEM_DEPTH     = 256;
	localparam int          FIFO_DEPTH    = 8;
	localparam logic [7:0]  PTR_RST       = 8'h00;
	localparam logic [3:0]  BIT_LAST      = 4'h8;
	localparam int          CODE_MSB      = 7;
	localparam int          CODE_LSB      = 4;
	localparam int          SEL_MSB       = 3;
	localparam int          SEL_LSB       = 1;
	localparam int          DIR_BIT       = 0;
	localparam logic [3:0]  DEV_CODE_DFLT = 4'h5;   // Arbitrary type code value
	localparam int          CLK_PERIOD_NS = 40;
	localparam int          PROG_TIME_NS  = 1000000;
	localparam int          PROG_CYCLES   = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Byte kinds within a transfer
	localparam logic [1:0]  K_CTRL        = 2'h0;
	localparam logic [1:0]  K_ADDR        = 2'h1;
	localparam logic [1:0]  K_DATA        = 2'h2;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_RX   = 5'h02,
		ST_ACK  = 5'h04,
		ST_TX   = 5'h08,
		ST_MACK = 5'h10
	} sep_state_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} sep_wr_t;

endpackage : sep_pkg

//--- sep_eeprom.sv
/*
 * Two-wire EEPROM slave: addressing, busy polling, current, random and sequential reads,
 * plus a write queue drained into the array during the self-timed programming cycle.
 * Assumes scl_in and sda_in are synchronous to clk and sampled often enough to see every edge.
 */
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module sep_fifo #(
	parameter int W     = 16,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic         flush,
	// Fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] store [DEPTH];
	logic [AW:0]  wr_ptr;
	logic [AW:0]  rd_ptr;
	logic [AW:0]  next_wr_ptr;
	logic [AW:0]  next_rd_ptr;

	assign in_ready  = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
	assign out_valid = (wr_ptr != rd_ptr);
	assign out_data  = store[rd_ptr[AW-1:0]];

	always_comb begin
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		if (flush) begin
			next_wr_ptr = rd_ptr;
		end else begin
			if (in_valid && in_ready) begin
				next_wr_ptr = wr_ptr + 1'b1;
			end
			if (out_valid && out_ready) begin
				next_rd_ptr = rd_ptr + 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
		end
	end

	always_ff @(posedge clk) begin
		if (in_valid && in_ready && !flush) begin
			store[wr_ptr[AW-1:0]] <= in_data;
		end
	end

endmodule : sep_fifo

////////////////////////////////////////////////////////////////////////////////
module sep_eeprom #(
	parameter logic [3:0] DEV_CODE    = sep_pkg::DEV_CODE_DFLT,  // Arbitrary type code
	parameter int         PROG_CYCLES = sep_pkg::PROG_CYCLES
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       resetn,
	// Select straps
	input  wire logic [2:0] chip_select_pins,
	// Two-wire bus
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_n,
	// Status
	output logic            prog_busy
);
	sep_pkg::sep_state_t st;
	sep_pkg::sep_state_t next_st;
	logic [7:0]  ptr;
	logic [7:0]  next_ptr;
	logic [3:0]  bit_cnt;
	logic [3:0]  next_bit_cnt;
	logic [1:0]  kind;
	logic [1:0]  next_kind;
	logic [7:0]  rx_shift;
	logic [7:0]  next_rx_shift;
	logic [7:0]  tx_shift;
	logic [7:0]  next_tx_shift;
	logic        read_mode;
	logic        next_read_mode;
	logic        mack_nak;
	logic        next_mack_nak;
	logic        wr_pending;
	logic        next_wr_pending;
	logic        next_sda_oe_n;
	logic        scl_q;
	logic        sda_q;
	logic        next_prog_busy;
	logic [23:0] prog_cnt;
	logic [23:0] next_prog_cnt;

	logic        scl_rise;
	logic        scl_fall;
	logic        ev_start;
	logic        ev_stop;
	logic        sel_match;
	logic [7:0]  mem_q;
	logic        push_valid;
	logic        push_ready;
	logic        fifo_flush;
	logic        drain_valid;
	logic [15:0] drain_raw;
	sep_pkg::sep_wr_t push_word;
	sep_pkg::sep_wr_t drain_word;

	logic [7:0]  mem [sep_pkg::MEM_DEPTH];

	////////////////////////////////////////////////////////////////////////////
	// Bus conditions
	assign scl_rise  = scl_in && !scl_q;
	assign scl_fall  = !scl_in && scl_q;
	assign ev_start  = scl_in && scl_q && sda_q && !sda_in;
	assign ev_stop   = scl_in && scl_q && !sda_q && sda_in;
	assign sel_match = (rx_shift[sep_pkg::CODE_MSB:sep_pkg::CODE_LSB] == DEV_CODE) &&
	                   (rx_shift[sep_pkg::SEL_MSB:sep_pkg::SEL_LSB] == chip_select_pins);
	assign mem_q     = mem[ptr];
	assign sda_out   = 1'b0;
	assign fifo_flush = ev_start && wr_pending;
	assign push_word = '{addr: ptr, data: rx_shift};

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_in;
			sda_q <= sda_in;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Serial sequencer
	always_comb begin
		next_st         = st;
		next_ptr        = ptr;
		next_bit_cnt    = bit_cnt;
		next_kind       = kind;
		next_rx_shift   = rx_shift;
		next_tx_shift   = tx_shift;
		next_read_mode  = read_mode;
		next_mack_nak   = mack_nak;
		next_wr_pending = wr_pending;
		next_sda_oe_n   = sda_oe_n;
		push_valid      = 1'b0;
		if (ev_start) begin
			next_st         = sep_pkg::ST_RX;
			next_bit_cnt    = 4'h0;
			next_kind       = sep_pkg::K_CTRL;
			next_sda_oe_n   = 1'b1;
			next_wr_pending = 1'b0;
		end else if (ev_stop) begin
			next_st         = sep_pkg::ST_IDLE;
			next_sda_oe_n   = 1'b1;
			next_wr_pending = 1'b0;
		end else begin
			unique case (st)
				sep_pkg::ST_IDLE: begin
				end
				sep_pkg::ST_RX: begin
					if (scl_rise && bit_cnt != sep_pkg::BIT_LAST) begin
						next_rx_shift = {rx_shift[6:0], sda_in};
						next_bit_cnt  = bit_cnt + 4'h1;
					end else if (scl_fall && bit_cnt == sep_pkg::BIT_LAST) begin
						next_sda_oe_n = 1'b1;
						next_st       = sep_pkg::ST_IDLE;
						unique case (kind)
							sep_pkg::K_CTRL: begin
								next_read_mode = rx_shift[sep_pkg::DIR_BIT];
								if (sel_match && !prog_busy) begin
									next_sda_oe_n = 1'b0;
									next_st       = sep_pkg::ST_ACK;
								end
							end
							sep_pkg::K_ADDR: begin
								next_ptr      = rx_shift;
								next_sda_oe_n = 1'b0;
								next_st       = sep_pkg::ST_ACK;
							end
							default: begin
								push_valid = 1'b1;
								if (push_ready) begin
									next_ptr        = ptr + 8'h01;
									next_wr_pending = 1'b1;
									next_sda_oe_n   = 1'b0;
									next_st         = sep_pkg::ST_ACK;
								end
							end
						endcase
					end
				end
				sep_pkg::ST_ACK: begin
					if (scl_fall) begin
						next_bit_cnt  = 4'h0;
						next_sda_oe_n = 1'b1;
						if (kind == sep_pkg::K_CTRL && read_mode) begin
							next_tx_shift = {mem_q[6:0], 1'b1};
							next_sda_oe_n = mem_q[7];
							next_ptr      = ptr + 8'h01;
							next_bit_cnt  = 4'h1;
							next_st       = sep_pkg::ST_TX;
						end else begin
							next_kind = (kind == sep_pkg::K_CTRL) ? sep_pkg::K_ADDR : sep_pkg::K_DATA;
							next_st   = sep_pkg::ST_RX;
						end
					end
				end
				sep_pkg::ST_TX: begin
					if (scl_fall) begin
						if (bit_cnt == sep_pkg::BIT_LAST) begin
							next_sda_oe_n = 1'b1;
							next_st       = sep_pkg::ST_MACK;
						end else begin
							next_sda_oe_n = tx_shift[7];
							next_tx_shift = {tx_shift[6:0], 1'b1};
							next_bit_cnt  = bit_cnt + 4'h1;
						end
					end
				end
				sep_pkg::ST_MACK: begin
					if (scl_rise) begin
						next_mack_nak = sda_in;
					end else if (scl_fall) begin
						if (!mack_nak) begin
							next_tx_shift = {mem_q[6:0], 1'b1};
							next_sda_oe_n = mem_q[7];
							next_ptr      = ptr + 8'h01;
							next_bit_cnt  = 4'h1;
							next_st       = sep_pkg::ST_TX;
						end else begin
							next_sda_oe_n = 1'b1;
							next_st       = sep_pkg::ST_IDLE;
						end
					end
				end
				default: begin
					next_st       = sep_pkg::ST_IDLE;
					next_sda_oe_n = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st         <= sep_pkg::ST_IDLE;
			ptr        <= sep_pkg::PTR_RST;
			bit_cnt    <= 4'h0;
			kind       <= sep_pkg::K_CTRL;
			rx_shift   <= 8'h00;
			tx_shift   <= 8'hFF;
			read_mode  <= 1'b0;
			mack_nak   <= 1'b1;
			wr_pending <= 1'b0;
			sda_oe_n   <= 1'b1;
		end else begin
			st         <= next_st;
			ptr        <= next_ptr;
			bit_cnt    <= next_bit_cnt;
			kind       <= next_kind;
			rx_shift   <= next_rx_shift;
			tx_shift   <= next_tx_shift;
			read_mode  <= next_read_mode;
			mack_nak   <= next_mack_nak;
			wr_pending <= next_wr_pending;
			sda_oe_n   <= next_sda_oe_n;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Write queue and self-timed programming
	sep_fifo #(
		.W     (16),
		.DEPTH (sep_pkg::FIFO_DEPTH)
	) u_wr_fifo (
		.clk       (clk),
		.resetn    (resetn),
		.flush     (fifo_flush),
		.in_valid  (push_valid),
		.in_ready  (push_ready),
		.in_data   (push_word),
		.out_valid (drain_valid),
		.out_ready (prog_busy),
		.out_data  (drain_raw)
	);

	assign drain_word = drain_raw;

	always_comb begin
		next_prog_busy = prog_busy;
		next_prog_cnt  = prog_cnt;
		if (!prog_busy) begin
			if (ev_stop && wr_pending) begin
				next_prog_busy = 1'b1;
				next_prog_cnt  = 24'h000000;
			end
		end else if (prog_cnt != 24'(PROG_CYCLES - 1)) begin
			next_prog_cnt = prog_cnt + 24'h000001;
		end else if (!drain_valid) begin
			next_prog_busy = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			prog_busy <= 1'b0;
			prog_cnt  <= 24'h000000;
		end else begin
			prog_busy <= next_prog_busy;
			prog_cnt  <= next_prog_cnt;
		end
	end

	always_ff @(posedge clk) begin
		if (drain_valid && prog_busy) begin
			mem[drain_word.addr] <= drain_word.data;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_ctrl_done;
		st == sep_pkg::ST_RX && scl_fall && bit_cnt == sep_pkg::BIT_LAST && kind == sep_pkg::K_CTRL &&
		!ev_start && !ev_stop;
	endsequence

	sequence s_byte_sent;
		st == sep_pkg::ST_TX && scl_fall && bit_cnt == sep_pkg::BIT_LAST && !ev_start && !ev_stop;
	endsequence

	a_busy_no_ack: assert property (s_ctrl_done and prog_busy |=> st == sep_pkg::ST_IDLE && sda_oe_n)
		else $error("acknowledge given while programming");
	a_prog_begins: assert property (ev_stop && wr_pending && !prog_busy |=> prog_busy)
		else $error("programming did not start at stop");
	a_free_acks: assert property (s_ctrl_done and (sel_match && !prog_busy) |=> !sda_oe_n)
		else $error("matching address not acknowledged when idle");
	a_wrong_sel: assert property (s_ctrl_done and !sel_match |=> sda_oe_n [*2])
		else $error("acknowledge on non-matching address");
	a_addr_loads: assert property (st == sep_pkg::ST_RX && scl_fall && bit_cnt == sep_pkg::BIT_LAST &&
		kind == sep_pkg::K_ADDR && !ev_start && !ev_stop |=> ptr == $past(rx_shift))
		else $error("word address not loaded");
	a_read_byte: assert property (st == sep_pkg::ST_ACK && scl_fall && read_mode &&
		kind == sep_pkg::K_CTRL && !ev_start && !ev_stop |=> st == sep_pkg::ST_TX &&
		sda_oe_n == $past(mem_q[7]) && ptr == $past(ptr) + 8'h01)
		else $error("read byte or pointer advance wrong");
	a_ptr_wraps: assert property (st == sep_pkg::ST_MACK && scl_fall && !mack_nak && ptr == 8'hFF &&
		!ev_start && !ev_stop |=> ptr == 8'h00)
		else $error("pointer did not wrap");
	a_seq_ack: assert property (s_byte_sent ##[1:8] (st == sep_pkg::ST_MACK && scl_rise && !sda_in &&
		!ev_start && !ev_stop) ##[1:8] (st == sep_pkg::ST_MACK && scl_fall && !ev_start && !ev_stop) |=>
		st == sep_pkg::ST_TX)
		else $error("next byte not sent after master ack");
	a_nack_release: assert property (st == sep_pkg::ST_MACK && scl_fall && mack_nak &&
		!ev_start && !ev_stop |=> sda_oe_n && st == sep_pkg::ST_IDLE)
		else $error("line not released after master nack");
	a_cond_resets: assert property (ev_start || ev_stop |=> sda_oe_n &&
		($past(ev_start) ? (st == sep_pkg::ST_RX && bit_cnt == 4'h0) : st == sep_pkg::ST_IDLE))
		else $error("start or stop did not reset sequencer");

endmodule : sep_eeprom

//--- sep_master.sv
/*
 * Behavioural two-wire bus master facing the EEPROM slave: start, stop, byte send, byte receive.
 * Assumes the bench resolves the shared data wire with a pull-up and feeds it back on sda.
 */
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module sep_master (
	// Clock
	input  wire logic clk,
	// Two-wire bus
	input  wire logic sda,
	output logic      scl,
	output logic      m_low
);

	initial begin
		scl = 1'b1;
		m_low = 1'b0;
	end

	// Step just after the rising edge
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wt

	// Also serves as repeated start
	task automatic start_cond();
		m_low = 1'b0;
		wt(2);
		scl = 1'b1;
		wt(4);
		m_low = 1'b1;
		wt(4);
		scl = 1'b0;
		wt(2);
	endtask : start_cond

	task automatic stop_cond();
		m_low = 1'b1;
		wt(2);
		scl = 1'b1;
		wt(4);
		m_low = 1'b0;
		wt(4);
	endtask : stop_cond

	task automatic put_bit(input logic b, output logic r);
		m_low = !b;
		wt(2);
		scl = 1'b1;
		wt(4);
		r = sda;
		scl = 1'b0;
		wt(2);
	endtask : put_bit

	task automatic tx_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			put_bit(d[i], r);
		end
		put_bit(1'b1, r);
		ack = !r;
	endtask : tx_byte

	task automatic rx_byte(input logic mack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			put_bit(1'b1, r);
			d[i] = r;
		end
		put_bit(!mack, r);
	endtask : rx_byte

endmodule : sep_master

//--- tb_top.sv
/*
 * Self-checking bench for the EEPROM read and busy-poll slave.
 * Assumes the partner master model; programming time shortened to 400 cycles.
 */
`timescale 1ns/1ps

`define CHK(nm, e, s) begin check_count++; if ((e) !== (s)) begin miscompares++; \
	$display("wrong value %s expected %h seen %h", nm, e, s); end end

////////////////////////////////////////////////////////////////////////////////
module tb_top;

	typedef struct {logic [7:0] a; int n;} sep_row_t;

	logic       clk = 1'b0;
	logic       resetn = 1'b0;
	logic [2:0] cs = 3'h5;
	logic       scl;
	logic       m_low;
	wire logic  sda_w;
	logic       sda_out;
	logic       sda_oe_n;
	logic       prog_busy;
	logic [7:0] ptr;
	int         miscompares = 0;
	int         check_count = 0;
	int         cycles = 0;
	sep_row_t   rows [3] = '{'{8'hFE, 4}, '{8'h03, 2}, '{8'hFF, 1}};

	assign sda_w = (m_low || !sda_oe_n) ? 1'b0 : 1'b1;

	always #20 clk = ~clk;

	sep_eeprom #(.PROG_CYCLES(400)) dut_u (
		.clk              (clk),
		.resetn           (resetn),
		.chip_select_pins (cs),
		.scl_in           (scl),
		.sda_in           (sda_w),
		.sda_out          (sda_out),
		.sda_oe_n         (sda_oe_n),
		.prog_busy        (prog_busy)
	);

	sep_master bus_m (
		.clk   (clk),
		.sda   (sda_w),
		.scl   (scl),
		.m_low (m_low)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : complete_run

	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			miscompares++;
			complete_run();
		end
	end

	task automatic ctrl(input logic dir, output logic ack);
		bus_m.start_cond();
		bus_m.tx_byte({sep_pkg::DEV_CODE_DFLT, cs, dir}, ack);
	endtask : ctrl

	task automatic rd(input logic rnd, input logic [7:0] a, input int n);
		logic       ack;
		logic [7:0] d;
		if (rnd) begin
			ctrl(1'b0, ack);
			bus_m.tx_byte(a, ack);
			ptr = a;
		end
		ctrl(1'b1, ack);
		`CHK("read ack", 1'b1, ack)
		for (int k = 0; k < n; k++) begin
			bus_m.rx_byte(k < n - 1, d);
			`CHK("read data", ptr ^ 8'h5A, d)
			ptr = ptr + 8'h01;
		end
		`CHK("released after nack", 1'b1, sda_oe_n)
		bus_m.stop_cond();
	endtask : rd

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic       ack;
		logic       acked;
		int         nacks;
		logic [7:0] wa;
		bus_m.wt(4);
		`CHK("oe_n in reset", 1'b1, sda_oe_n)
		`CHK("busy in reset", 1'b0, prog_busy)
		`CHK("sda_out level", 1'b0, sda_out)
		resetn = 1'b1;
		bus_m.wt(2);
		$display("test reset done");
		// Write eight bytes across the top of the array
		ctrl(1'b0, ack);
		`CHK("write ctrl ack", 1'b1, ack)
		bus_m.tx_byte(8'hFE, ack);
		`CHK("word addr ack", 1'b1, ack)
		for (int i = 0; i < 8; i++) begin
			wa = 8'hFE + i[7:0];
			bus_m.tx_byte(wa ^ 8'h5A, ack);
			`CHK("data ack", 1'b1, ack)
		end
		`CHK("busy before stop", 1'b0, prog_busy)
		bus_m.stop_cond();
		`CHK("busy after stop", 1'b1, prog_busy)
		ctrl(1'b1, ack);
		`CHK("read ctrl while busy", 1'b0, ack)
		bus_m.stop_cond();
		acked = 1'b0;
		nacks = 0;
		for (int t = 0; t < 20 && !acked; t++) begin
			ctrl(1'b0, ack);
			bus_m.stop_cond();
			acked = ack;
			if (!ack) nacks++;
		end
		`CHK("poll nacked", 1'b1, nacks > 0)
		`CHK("poll acked", 1'b1, acked)
		`CHK("busy after poll", 1'b0, prog_busy)
		$display("test write and poll done");
		for (int r = 0; r < 3; r++) begin
			rd(1'b1, rows[r].a, rows[r].n);
			rd(1'b0, 8'h00, 1);
		end
		$display("test read rows done");
		// Wrong select, then wrong type code
		bus_m.start_cond();
		bus_m.tx_byte({sep_pkg::DEV_CODE_DFLT, cs ^ 3'h1, 1'b1}, ack);
		`CHK("wrong select ack", 1'b0, ack)
		bus_m.start_cond();
		bus_m.tx_byte({~sep_pkg::DEV_CODE_DFLT, cs, 1'b1}, ack);
		`CHK("wrong code ack", 1'b0, ack)
		bus_m.stop_cond();
		$display("test select done");
		// Address-only write, then current read
		ctrl(1'b0, ack);
		bus_m.tx_byte(8'h04, ack);
		bus_m.stop_cond();
		`CHK("no busy on addr-only", 1'b0, prog_busy)
		ptr = 8'h04;
		rd(1'b0, 8'h00, 2);
		$display("test address load done");
		// Second reset returns pointer to zero
		resetn = 1'b0;
		bus_m.wt(2);
		resetn = 1'b1;
		bus_m.wt(2);
		`CHK("oe_n after reset", 1'b1, sda_oe_n)
		ptr = 8'h00;
		rd(1'b0, 8'h00, 1);
		$display("test second reset done");
		complete_run();
	end

endmodule : tb_top
